// ### pdp_pkg.sv
// constants, field layout and types for the diagnostic / power-mode registers
// How it works
// - peak polarity flags sit in bits 14..11, peak 4 highest; 1 is negative
// - peak 4 and 3 flags count only if second location high/low byte nonzero
// - peak 2 and 1 flags count only if first location high/low byte nonzero
// - operation-select bit 6 resets from the strap; 1 autonomous, 0 managed
// - after the first read or write of that bit it always reads zero
// - managed operation comes only from the strap at reset, never by writes
// - finished sleep negotiation goes to Sleep if sleep enable set, else Standby
// - sleep code-groups go out only while transmission enable bit 0 is set
// - sleep-request bit 1 set makes the device send sleep code-groups while in the Normal power state
// - normal-command bit 0 set forces the Normal power state
// - normal-command bit clears itself only on Standby to Normal
// - ratio register bits 8..0 hold ten times the measured ratio in dB
// - the ratio result means something only while the link is up
// - two location registers hold peaks 1..4, low byte first
package pdp_pkg;

    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_PEAK_LOC_FIRST = 10'h180;
    localparam logic [9:0] IDX_PEAK_LOC_SECOND = 10'h181;
    localparam logic [9:0] IDX_PEAK_POLARITY = 10'h18A;
    localparam logic [9:0] IDX_AUTONOMOUS_OP = 10'h18B;
    localparam logic [9:0] IDX_POWER_MODE = 10'h18C;
    localparam logic [9:0] IDX_NOISE_RATIO = 10'h197;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POL_PEAK1_BIT = 11;
    localparam int POL_PEAK2_BIT = 12;
    localparam int POL_PEAK3_BIT = 13;
    localparam int POL_PEAK4_BIT = 14;
    localparam int AUTO_CMD_BIT = 6;
    localparam int AUTO_RSVD_LSB = 2;
    localparam int AUTO_SLEEP_EN_BIT = 1;
    localparam int AUTO_LPS_TX_EN_BIT = 0;
    localparam int PWR_SLEEP_REQ_BIT = 1;
    localparam int PWR_NORMAL_CMD_BIT = 0;
    localparam int SNR_WIDTH = 9;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] AUTO_RSVD_VALUE = 4'h6;
    localparam logic RST_SLEEP_EN = 1'b1;
    localparam logic RST_LPS_TX_EN = 1'b0;
    localparam logic RST_SLEEP_REQ = 1'b0;
    localparam logic RST_NORMAL_CMD = 1'b0;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ------------------------------------------------------------
    // power states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PDP_NORMAL,
        PDP_STANDBY,
        PDP_SLEEP
    } pdp_power_t;

endpackage

// ### pdp_in_sync.sv
// reset release and strap pin synchroniser
`timescale 1ns/1ps
module pdp_in_sync (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic strap_pin,
    output logic rst_sync_b,
    output logic strap_sync
);

    logic rst_meta;
    logic strap_meta;

    // ------------------------------------------------------------
    // reset release through two flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // strap level, no reset so it is valid at release
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        strap_meta <= strap_pin;
        strap_sync <= strap_meta;
    end

endmodule

// ### pdp_power_fsm.sv
// power state machine: normal, standby, sleep
`timescale 1ns/1ps
module pdp_power_fsm (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic lps_neg_done,
    input wire logic wake_event,
    input wire logic sleep_enable,
    input wire logic normal_cmd,
    output pdp_pkg::pdp_power_t state,
    output logic standby_exit
);

    pdp_pkg::pdp_power_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            pdp_pkg::PDP_NORMAL: begin
                if (lps_neg_done && !normal_cmd) begin
                    if (sleep_enable) begin
                        next_state = pdp_pkg::PDP_SLEEP;
                    end else begin
                        next_state = pdp_pkg::PDP_STANDBY;
                    end
                end
            end
            pdp_pkg::PDP_STANDBY: begin
                if (normal_cmd) begin
                    next_state = pdp_pkg::PDP_NORMAL;
                end
            end
            pdp_pkg::PDP_SLEEP: begin
                if (normal_cmd) begin
                    next_state = pdp_pkg::PDP_NORMAL;
                end else if (wake_event) begin
                    next_state = pdp_pkg::PDP_STANDBY;
                end
            end
            default: begin
                next_state = pdp_pkg::PDP_NORMAL;
            end
        endcase
    end

    // pulse that clears the normal command
    assign standby_exit = (state == pdp_pkg::PDP_STANDBY) &&
                          (next_state == pdp_pkg::PDP_NORMAL);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= pdp_pkg::PDP_NORMAL;
        end else begin
            state <= next_state;
        end
    end

endmodule

// ### pdp_regs.sv
// diagnostic and power-mode register bank on an avalon-mm slave
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pdp_regs (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic autonomous_strap,
    input wire logic [7:0] peak1_location,
    input wire logic [7:0] peak2_location,
    input wire logic [7:0] peak3_location,
    input wire logic [7:0] peak4_location,
    input wire logic [3:0] peak_negative,
    input wire logic [8:0] snr_tenths,
    input wire logic link_up,
    input wire logic lps_neg_done,
    input wire logic wake_event,
    output logic autonomous_mode,
    output logic sleep_enable,
    output logic lps_code_tx_en,
    output pdp_pkg::pdp_power_t power_state
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic rst_n;
    logic strap_sync;
    logic standby_exit;
    logic ack;
    logic next_ack;
    logic [31:0] next_readdata;
    logic [9:0] idx;
    logic req;
    logic taken;
    logic wr_taken;
    logic strap_taken;
    logic next_strap_taken;
    logic next_autonomous_mode;
    logic auto_accessed;
    logic next_auto_accessed;
    logic next_sleep_enable;
    logic lps_tx_enable;
    logic next_lps_tx_enable;
    logic sleep_request;
    logic next_sleep_request;
    logic normal_cmd;
    logic next_normal_cmd;
    logic next_lps_code_tx_en;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic nonzero(input logic [7:0] loc);
        nonzero = |loc;
    endfunction

    function automatic logic [31:0] read_mux(
        input logic [9:0] index,
        input logic [7:0] l1,
        input logic [7:0] l2,
        input logic [7:0] l3,
        input logic [7:0] l4,
        input logic [3:0] neg,
        input logic auto_bit,
        input logic slp_en,
        input logic tx_en,
        input logic slp_req,
        input logic nrm_cmd,
        input logic [8:0] noise_ratio_result,
        input logic link
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (index)
            pdp_pkg::IDX_PEAK_LOC_FIRST: begin
                d[15:0] = {l2, l1};
            end
            pdp_pkg::IDX_PEAK_LOC_SECOND: begin
                d[15:0] = {l4, l3};
            end
            pdp_pkg::IDX_PEAK_POLARITY: begin
                d[pdp_pkg::POL_PEAK4_BIT] = neg[3] & nonzero(l4);
                d[pdp_pkg::POL_PEAK3_BIT] = neg[2] & nonzero(l3);
                d[pdp_pkg::POL_PEAK2_BIT] = neg[1] & nonzero(l2);
                d[pdp_pkg::POL_PEAK1_BIT] = neg[0] & nonzero(l1);
            end
            pdp_pkg::IDX_AUTONOMOUS_OP: begin
                d[pdp_pkg::AUTO_CMD_BIT] = auto_bit;
                d[pdp_pkg::AUTO_RSVD_LSB +: 4] = pdp_pkg::AUTO_RSVD_VALUE;
                d[pdp_pkg::AUTO_SLEEP_EN_BIT] = slp_en;
                d[pdp_pkg::AUTO_LPS_TX_EN_BIT] = tx_en;
            end
            pdp_pkg::IDX_POWER_MODE: begin
                d[pdp_pkg::PWR_SLEEP_REQ_BIT] = slp_req;
                d[pdp_pkg::PWR_NORMAL_CMD_BIT] = nrm_cmd;
            end
            pdp_pkg::IDX_NOISE_RATIO: begin
                if (link) begin
                    d[pdp_pkg::SNR_WIDTH-1:0] = noise_ratio_result;
                end
            end
            default: begin
                d = pdp_pkg::UNMAPPED_READ;
            end
        endcase
        read_mux = d;
    endfunction

    // ------------------------------------------------------------
    // reset release, strap sampling and power state
    // ------------------------------------------------------------
    pdp_in_sync u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .strap_pin(autonomous_strap),
        .rst_sync_b(rst_n),
        .strap_sync(strap_sync)
    );

    pdp_power_fsm u_fsm (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .lps_neg_done(lps_neg_done),
        .wake_event(wake_event),
        .sleep_enable(sleep_enable),
        .normal_cmd(normal_cmd),
        .state(power_state),
        .standby_exit(standby_exit)
    );

    // ------------------------------------------------------------
    // bus handshake: one wait cycle per access
    // ------------------------------------------------------------
    assign idx = avs_address[11:2];
    assign req = avs_read | avs_write;
    assign taken = req & ack;
    assign wr_taken = avs_write & ack;
    assign avs_waitrequest = req & ~ack;

    always_comb begin
        next_ack = req & ~ack;
        next_readdata = avs_readdata;
        if (avs_read && !ack) begin
            next_readdata = read_mux(idx, peak1_location, peak2_location,
                peak3_location, peak4_location, peak_negative,
                autonomous_mode & ~auto_accessed, sleep_enable,
                lps_tx_enable, sleep_request, normal_cmd, snr_tenths,
                link_up);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack <= next_ack;
            avs_readdata <= next_readdata;
        end
    end

    // ------------------------------------------------------------
    // operation select and sleep control
    // ------------------------------------------------------------
    always_comb begin
        next_strap_taken = 1'b1;
        next_autonomous_mode = autonomous_mode;
        if (!strap_taken) begin
            next_autonomous_mode = strap_sync;
        end
        next_auto_accessed = auto_accessed;
        if (taken && idx == pdp_pkg::IDX_AUTONOMOUS_OP) begin
            next_auto_accessed = 1'b1;
        end
        next_sleep_enable = sleep_enable;
        next_lps_tx_enable = lps_tx_enable;
        if (wr_taken && idx == pdp_pkg::IDX_AUTONOMOUS_OP &&
            avs_byteenable[0]) begin
            next_sleep_enable = avs_writedata[pdp_pkg::AUTO_SLEEP_EN_BIT];
            next_lps_tx_enable = avs_writedata[pdp_pkg::AUTO_LPS_TX_EN_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_taken <= 1'b0;
            autonomous_mode <= 1'b0;
            auto_accessed <= 1'b0;
            sleep_enable <= pdp_pkg::RST_SLEEP_EN;
            lps_tx_enable <= pdp_pkg::RST_LPS_TX_EN;
        end else begin
            strap_taken <= next_strap_taken;
            autonomous_mode <= next_autonomous_mode;
            auto_accessed <= next_auto_accessed;
            sleep_enable <= next_sleep_enable;
            lps_tx_enable <= next_lps_tx_enable;
        end
    end

    // ------------------------------------------------------------
    // power mode commands
    // ------------------------------------------------------------
    always_comb begin
        next_sleep_request = sleep_request;
        next_normal_cmd = normal_cmd;
        if (standby_exit) begin
            next_normal_cmd = 1'b0;
        end
        if (wr_taken && idx == pdp_pkg::IDX_POWER_MODE &&
            avs_byteenable[0]) begin
            next_sleep_request = avs_writedata[pdp_pkg::PWR_SLEEP_REQ_BIT];
            if (avs_writedata[pdp_pkg::PWR_NORMAL_CMD_BIT]) begin
                next_normal_cmd = 1'b1;
            end else if (!standby_exit) begin
                next_normal_cmd = 1'b0;
            end
        end
        next_lps_code_tx_en = lps_tx_enable & sleep_request &
            (power_state == pdp_pkg::PDP_NORMAL);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_request <= pdp_pkg::RST_SLEEP_REQ;
            normal_cmd <= pdp_pkg::RST_NORMAL_CMD;
            lps_code_tx_en <= 1'b0;
        end else begin
            sleep_request <= next_sleep_request;
            normal_cmd <= next_normal_cmd;
            lps_code_tx_en <= next_lps_code_tx_en;
        end
    end

endmodule

// ### pdp_link_partner.sv
// remote link partner model: sleep negotiation, wake and link status
`timescale 1ns/1ps
module pdp_link_partner (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic lps_code_tx_en,
    input wire logic slow,
    input wire logic wake_req,
    input wire logic link_req,
    output logic lps_neg_done,
    output logic wake_event,
    output logic link_up
);
    int cnt;
    logic hit;
    // answers only while sleep code-groups are heard, promptly or slowly
    assign hit = lps_code_tx_en && cnt == (slow ? 6 : 2);
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            lps_neg_done <= 1'b0;
            wake_event <= 1'b0;
            link_up <= 1'b0;
        end else begin
            cnt <= (lps_code_tx_en && !hit) ? cnt + 1 : 0;
            lps_neg_done <= hit;
            wake_event <= wake_req;
            link_up <= link_req;
        end
    end
endmodule

// ### pdp_regs_checker.sv
// assertions on the diagnostic and power-mode register bank
`timescale 1ns/1ps
module pdp_regs_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [8:0] snr_tenths,
    input wire logic link_up,
    input wire logic lps_neg_done,
    input wire logic wake_event,
    input wire logic autonomous_mode,
    input wire logic sleep_enable,
    input wire logic lps_code_tx_en,
    input wire pdp_pkg::pdp_power_t power_state
);
    wire [9:0] idx = avs_address[11:2];
    wire take = (avs_read || avs_write) && !avs_waitrequest;
    wire rd_ok = avs_read && !avs_waitrequest;
    wire rd_auto = rd_ok && idx == pdp_pkg::IDX_AUTONOMOUS_OP;
    wire nrm_wr = take && avs_write && idx == pdp_pkg::IDX_POWER_MODE;
    logic [2:0] age;
    logic seen;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            age <= 3'h0;
            seen <= 1'b0;
        end else begin
            if (age != 3'h5) age <= age + 3'h1;
            if (take && idx == pdp_pkg::IDX_AUTONOMOUS_OP) seen <= 1'b1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    strap_read_a: assert property (rd_auto && !seen |->
        avs_readdata[6] == autonomous_mode) else $error("bit 6 not strap");
    one_shot_a: assert property (rd_auto && seen |->
        !avs_readdata[6]) else $error("bit 6 read after access");
    mode_hold_a: assert property (age == 3'h5 |->
        $stable(autonomous_mode)) else $error("mode changed");
    reserved_bits_a: assert property (rd_auto |->
        avs_readdata[5:2] == pdp_pkg::AUTO_RSVD_VALUE
        && avs_readdata[15:7] == 9'h000) else $error("reserved bits");
    sleep_entry_a: assert property ($changed(power_state) &&
        power_state == pdp_pkg::PDP_SLEEP |-> $past(lps_neg_done)
        && $past(sleep_enable)) else $error("bad sleep entry");
    standby_entry_a: assert property ($changed(power_state) &&
        power_state == pdp_pkg::PDP_STANDBY |-> $past(wake_event) ||
        ($past(lps_neg_done) && !$past(sleep_enable)))
        else $error("bad standby entry");
    normal_force_a: assert property (nrm_wr && avs_writedata[0] &&
        avs_byteenable[0] |-> ##[1:2] power_state == pdp_pkg::PDP_NORMAL)
        else $error("normal command ignored");
    lps_gate_a: assert property (lps_code_tx_en |->
        $past(power_state) == pdp_pkg::PDP_NORMAL) else $error("lps tx");
    ratio_read_a: assert property (rd_ok &&
        idx == pdp_pkg::IDX_NOISE_RATIO |-> avs_readdata[15:0] ==
        ($past(link_up) ? {7'h00, $past(snr_tenths)} : 16'h0000))
        else $error("ratio read");
endmodule
bind pdp_regs pdp_regs_checker i_pdp_regs_checker (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .snr_tenths(snr_tenths),
    .link_up(link_up),
    .lps_neg_done(lps_neg_done),
    .wake_event(wake_event),
    .autonomous_mode(autonomous_mode),
    .sleep_enable(sleep_enable),
    .lps_code_tx_en(lps_code_tx_en),
    .power_state(power_state)
);

// ### pdp_regs_test.sv
// self-checking bench for the diagnostic and power-mode register bank
`timescale 1ns/1ps
module pdp_regs_test;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, autonomous_mode, sleep_enable, lps_code_tx_en;
    logic strap = 1'b1, link_req = 1'b0, slow = 1'b0, wake_req = 1'b0;
    logic [7:0] p1 = 8'h00, p2 = 8'h00, p3 = 8'h00, p4 = 8'h00;
    logic [3:0] neg = 4'h0;
    logic [8:0] noise_ratio_result = 9'h000;
    logic lps_neg_done, wake_event, link_up;
    pdp_pkg::pdp_power_t power_state;
    logic [15:0] q;
    logic [31:0] r;
    logic seen, m_se, m_en, m_req, m_nrm;
    int n_fail = 0;
    int check_count = 0;
    always #5 sys_clk = ~sys_clk;
    pdp_regs i_pdp_regs (.sys_clk(sys_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .autonomous_strap(strap),
        .peak1_location(p1), .peak2_location(p2), .peak3_location(p3),
        .peak4_location(p4), .peak_negative(neg), .snr_tenths(noise_ratio_result),
        .link_up(link_up), .lps_neg_done(lps_neg_done),
        .wake_event(wake_event), .autonomous_mode(autonomous_mode),
        .sleep_enable(sleep_enable), .lps_code_tx_en(lps_code_tx_en),
        .power_state(power_state));
    pdp_link_partner i_pdp_link_partner (.sys_clk(sys_clk), .rst_b(rst_b),
        .lps_code_tx_en(lps_code_tx_en), .slow(slow), .wake_req(wake_req),
        .link_req(link_req), .lps_neg_done(lps_neg_done),
        .wake_event(wake_event), .link_up(link_up));
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] want);
        check_count++;
        if (got !== want) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
        end
    endtask
    task chk_state(input pdp_pkg::pdp_power_t want);
        check_count++;
        if (power_state !== want) begin
            n_fail++;
            $display("CHECK FAILED t=%0t power state %0d", $time, power_state);
        end
    endtask
    task bus(input logic wr, input logic [11:0] a, input logic [15:0] d);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0000, d};
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            n_fail++;
            finish_test();
        end
        q = avs_readdata[15:0];
        if (!wr) chk(avs_readdata[31:16], 16'h0000);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [15:0] want);
        bus(1'b0, a, 16'h0000);
        chk(q, want);
    endtask
    task wr_auto(input logic [15:0] d);
        bus(1'b1, 12'h62C, d);
        {seen, m_se, m_en} = {1'b1, d[1:0]};
    endtask
    task rd_auto;
        rd(12'h62C, {9'h000, strap & ~seen, 4'h6, m_se, m_en});
        chk(sleep_enable, m_se);
        seen = 1'b1;
    endtask
    task wr_pwr(input logic [1:0] d);
        bus(1'b1, 12'h630, {14'h0000, d});
        {m_req, m_nrm} = d;
    endtask
    task wait_state(input pdp_pkg::pdp_power_t s);
        int n;
        for (n = 0; n < 60 && power_state !== s; n++) @(negedge sys_clk);
        chk_state(s);
        if (n == 60) finish_test();
    endtask
    task do_reset(input logic s);
        strap <= s;
        rst_b <= 1'b0;
        {seen, m_se, m_en, m_req, m_nrm} = 5'b01000;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
    initial begin
        void'($urandom(32'h76CDB83D));
        for (int k = 0; k < 3; k++) begin
            do_reset(k < 2);
            chk(autonomous_mode, k < 2);
            if (k == 1) wr_auto(16'hFF83);
            rd_auto();
            rd_auto();
            chk(autonomous_mode, k < 2);
        end
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            p1 <= i[0] ? 8'h00 : r[7:0];
            p2 <= i[1] ? 8'h00 : r[15:8];
            p3 <= i[2] ? 8'h00 : r[23:16];
            p4 <= i[3] ? 8'h00 : r[31:24];
            neg <= 4'($urandom);
            noise_ratio_result <= 9'($urandom);
            link_req <= 1'($urandom);
            bus(1'b1, 12'h628, r[15:0]);
            rd(12'h600, {p2, p1});
            rd(12'h604, {p4, p3});
            rd(12'h628, {1'b0, neg & {p4 != 0, p3 != 0, p2 != 0, p1 != 0},
                11'h000});
            rd(12'h65C, link_req ? {7'h00, noise_ratio_result} : 16'h0000);
            rd(12'h700, 16'h0000);
        end
        avs_byteenable <= 4'hE;
        bus(1'b1, 12'h630, 16'h0003);
        avs_byteenable <= 4'hF;
        rd(12'h630, 16'h0000);
        wr_pwr(2'b10);
        repeat (20) @(posedge sys_clk);
        chk(lps_code_tx_en, 16'h0000);
        chk_state(pdp_pkg::PDP_NORMAL);
        slow <= 1'b1;
        wr_auto(16'h0003);
        repeat (2) @(posedge sys_clk);
        chk(lps_code_tx_en, 16'h0001);
        wait_state(pdp_pkg::PDP_SLEEP);
        @(posedge sys_clk);
        wake_req <= 1'b1;
        @(posedge sys_clk);
        wake_req <= 1'b0;
        wait_state(pdp_pkg::PDP_STANDBY);
        slow <= 1'b0;
        wr_pwr(2'b11);
        wait_state(pdp_pkg::PDP_NORMAL);
        m_nrm = 1'b0;
        rd(12'h630, {14'h0000, m_req, m_nrm});
        wait_state(pdp_pkg::PDP_SLEEP);
        wr_pwr(2'b11);
        wait_state(pdp_pkg::PDP_NORMAL);
        rd(12'h630, {14'h0000, m_req, m_nrm});
        wr_auto(16'h0001);
        wr_pwr(2'b10);
        wait_state(pdp_pkg::PDP_STANDBY);
        rd_auto();
        finish_test();
    end
endmodule
